// ===== logic/cm_macrocell.sv
// one logic cell: product terms, selector, sum stage, storage and pin control
//
// What this block does
// [R1] five product terms over global and regional bus
// [R2] selector routes each term to sum or control
// [R3] five-term OR sum, cascade extends it
// [R4] XOR second input: term, zero or one
// [R5] XOR with feedback emulates toggle and JK
// [R6] data from XOR, separate term or pin
// [R7] D, T, JK, SR and level latch modes
// [R8] clock from global line or term, rising
// [R9] term enable low blocks global clock edges
// [R10] clear from global line, term, OR, off
// [R11] preset from term or off, sets asynchronously
// [R12] output and feedback each registered or combinatorial
// [R13] pin mode and enable selection per pin
// [R14] input-only pin keeps whole cell usable
// [R15] switch matrix picks forty from global bus
// [R16] foldback drives inverted term to regional bus
// [R17] signature readable despite the security fuse
// [R18] open-collector option drives only low
// [R19] clear beats preset when both asserted
`timescale 1ns/1ps
`include "cm_regs.svh"

module cm_macrocell #(
   parameter int GB_W = `CM_GBUS_W, // global bus width
   parameter int BLK_IN = `CM_BLK_IN, // switch matrix outputs
   parameter int REG_W = `CM_REG_BUS, // regional bus width
   parameter logic [`CM_SIG_W-1:0] USER_SIG = `CM_SIG_DEFAULT, // arbitrary value
   parameter int SEL_W = $clog2(GB_W) // matrix index width
) (
   input wire logic clk, // fabric clock
   input wire logic sys_rst, // synchronous reset, high
   input cm_pkg::cm_cfg_t cfg, // cell configuration
   input wire logic [GB_W-1:0] globalBus, // pins and all feedbacks
   input wire logic [BLK_IN-1:0][SEL_W-1:0] matrixSel, // bus index per block input
   input wire logic [REG_W-1:0] regionalBus, // foldback terms of region
   input wire logic [`CM_PT_NUM-1:0][BLK_IN+REG_W-1:0] ptTrueMask, // true-literal use
   input wire logic [`CM_PT_NUM-1:0][BLK_IN+REG_W-1:0] ptCompMask, // inverted-literal use
   input wire logic cascadeIn, // sum from neighbour
   input wire logic global_clock_line, // shared clock
   input wire logic global_clear_line, // shared clear
   input wire logic [1:0] oePins, // output enable pins
   input wire logic [`CM_OE_SUB_N-1:0] oeSubset, // pin or cell enables
   input wire logic padIn, // pin level
   input wire logic securityFuse, // contents locked
   output logic padOut, // pin drive value
   output logic padOe, // pin driven, high
   output logic cascadeOut, // sum to neighbour
   output logic feedbackOut, // buried feedback to bus
   output logic foldbackOut, // term to regional bus
   output logic [`CM_SIG_W-1:0] userSig, // user signature
   output logic [`CM_CFG_VIEW_W-1:0] cfgView // readback, zero if locked
);
   import cm_pkg::*;

   localparam int ARR_W = BLK_IN + REG_W;

   logic [BLK_IN-1:0] blkIn;
   logic [ARR_W-1:0] arrayIn;
   logic [`CM_PT_NUM-1:0] pt;
   logic [`CM_PT_NUM-1:0] ptSum;
   logic orLocal;
   logic sumTerm;
   logic xorOther;
   logic xorOut;
   logic dataIn;
   logic secIn;
   logic clkSrc;
   logic clkPrev_q;
   logic clkRise;
   logic clkEn;
   logic rstSrc;
   logic setSrc;
   cm_ff_ctl_t ffCtl;
   logic qState;
   logic qOut;
   logic cellValue;
   logic oeSel;
   cm_pad_t pad;

   // ==========================================
   // switch matrix and product terms
   always_comb begin
      for (int b = 0; b < BLK_IN; b++) begin
         blkIn[b] = (int'(matrixSel[b]) < GB_W) ? globalBus[matrixSel[b]] : 1'b0; // R15
      end
   end

   assign arrayIn = {regionalBus, blkIn}; // R1

   // an empty term (no literal used) reads high, like an unprogrammed AND
   always_comb begin
      for (int p = 0; p < `CM_PT_NUM; p++) begin
         pt[p] = &(~ptTrueMask[p] | arrayIn) & &(~ptCompMask[p] | ~arrayIn); // R1
      end
   end

   // ==========================================
   // sum, cascade and XOR
   assign ptSum = pt & cfg.ptToSum; // R2
   assign orLocal = |ptSum; // R3
   assign sumTerm = orLocal | (cfg.cascadeEn & cascadeIn); // R3
   assign cascadeOut = sumTerm; // R3

   always_comb begin
      unique case (cfg.xorSel)
         XOR_PT: xorOther = cm_pt_pick(pt, cfg.xorPt); // R4
         XOR_ZERO: xorOther = 1'b0; // R4
         XOR_ONE: xorOther = 1'b1; // R4
         XOR_FB: xorOther = qState; // R5
      endcase
   end

   assign xorOut = sumTerm ^ xorOther; // R4 R5

   // ==========================================
   // storage data and clocking
   always_comb begin
      unique case (cfg.dataSrc)
         DSRC_XOR: dataIn = xorOut; // R6
         DSRC_PT: dataIn = cm_pt_pick(pt, cfg.dataPt); // R6
         DSRC_PIN: dataIn = padIn; // R6
         default: dataIn = xorOut;
      endcase
   end

   assign secIn = cm_pt_pick(pt, cfg.secPt); // R7

   // macro clock is sampled on the fabric clock, so its edge is a one-cycle flag
   assign clkSrc = (cfg.clkSel == CK_GLOBAL) ? global_clock_line
      : cm_pt_pick(pt, cfg.clkPt); // R8

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clkPrev_q <= `CM_CLK_PREV_RST;
      end else begin
         clkPrev_q <= clkSrc;
      end
   end

   assign clkRise = clkSrc & ~clkPrev_q; // R8
   // the enable only exists on the global clock path
   assign clkEn = ~(cfg.clkSel == CK_GLOBAL && cfg.ceEn) | cm_pt_pick(pt, cfg.cePt); // R9

   // ==========================================
   // asynchronous clear and preset
   always_comb begin
      unique case (cfg.arSel)
         AR_GCLR: rstSrc = global_clear_line; // R10
         AR_PT: rstSrc = cm_pt_pick(pt, cfg.arPt); // R10
         AR_OR: rstSrc = global_clear_line | cm_pt_pick(pt, cfg.arPt); // R10
         AR_OFF: rstSrc = 1'b0; // R10
      endcase
   end

   assign setSrc = (cfg.apSel == AP_PT) ? cm_pt_pick(pt, cfg.apPt) : 1'b0; // R11

   always_comb begin
      ffCtl.clkRise = clkRise;
      ffCtl.clkLevel = clkSrc;
      ffCtl.clkEn = clkEn;
      ffCtl.asyncRst = rstSrc;
      ffCtl.asyncSet = setSrc;
   end

   cm_storage u_storage (
      .clk(clk),
      .sys_rst(sys_rst),
      .mode(cfg.mode),
      .dIn(dataIn),
      .kIn(secIn),
      .ctl(ffCtl),
      .qState(qState),
      .qOut(qOut)
   );

   // ==========================================
   // output, feedback and foldback
   assign cellValue = cfg.outReg ? qOut : xorOut; // R12
   // feedback ignores pin mode, so an input-only pin keeps the cell
   assign feedbackOut = cfg.fbReg ? qOut : xorOut; // R12 R14
   assign foldbackOut = ~cm_pt_pick(pt, cfg.foldPt); // R16

   // ==========================================
   // pin control
   always_comb begin
      unique case (cfg.oeSel)
         OE_EN0: oeSel = oePins[0]; // R13
         OE_EN0_N: oeSel = ~oePins[0]; // R13
         OE_EN1: oeSel = oePins[1]; // R13
         OE_EN1_N: oeSel = ~oePins[1]; // R13
         OE_SUBSET: oeSel = oeSubset[cfg.oeSubIdx]; // R13
         default: oeSel = 1'b0;
      endcase
   end

   always_comb begin
      unique case (cfg.ioMode)
         IO_IN: pad.oe = 1'b0; // R13 R14
         IO_OUT: pad.oe = 1'b1; // R13
         IO_BIDIR: pad.oe = oeSel; // R13
         default: pad.oe = 1'b0;
      endcase
      pad.out = cellValue;
      // wired-OR line: release the pin for a high, pull it for a low
      if (cfg.openDrain) begin
         pad.oe = pad.oe & ~cellValue; // R18
         pad.out = 1'b0; // R18
      end
   end

   assign padOut = pad.out;
   assign padOe = pad.oe;

   // ==========================================
   // signature and locked readback
   assign userSig = USER_SIG; // R17
   assign cfgView = securityFuse ? '0 : cfg[`CM_CFG_VIEW_W-1:0]; // R17

   // ==========================================
   // assertions
   sequence s_gclk_blocked;
      cfg.clkSel == CK_GLOBAL && cfg.ceEn && !cm_pt_pick(pt, cfg.cePt);
   endsequence

   sequence s_edge_taken;
      clkRise && clkEn;
   endsequence

   sequence s_no_async;
      !rstSrc && !setSrc;
   endsequence

   sequence s_d_load;
      cfg.mode == MODE_D && clkRise && clkEn;
   endsequence

   property p_ce_block;
      @(posedge clk) disable iff (sys_rst) s_gclk_blocked |-> !ffCtl.clkEn;
   endproperty
   a_ce_block: assert property (p_ce_block) else $error("edge passed a low enable"); // R9

   property p_rise_once;
      @(posedge clk) disable iff (sys_rst) s_edge_taken |=> !clkRise;
   endproperty
   a_rise_once: assert property (p_rise_once) else $error("edge flagged twice"); // R8

   property p_sum_local;
      @(posedge clk) disable iff (sys_rst)
         !cfg.cascadeEn |-> cascadeOut == |(pt & cfg.ptToSum);
   endproperty
   a_sum_local: assert property (p_sum_local) else $error("local sum wrong"); // R3

   property p_polarity;
      @(posedge clk) disable iff (sys_rst) cfg.xorSel == XOR_ONE |-> xorOut == !sumTerm;
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity not inverted"); // R4

   property p_fold;
      @(posedge clk) disable iff (sys_rst)
         cfg.foldPt < `CM_PT_NUM |-> foldbackOut != pt[cfg.foldPt];
   endproperty
   a_fold: assert property (p_fold) else $error("foldback not inverted"); // R16

   property p_input_only;
      @(posedge clk) disable iff (sys_rst) cfg.ioMode == IO_IN |-> !padOe;
   endproperty
   a_input_only: assert property (p_input_only) else $error("input pin driven"); // R13

   property p_open_drain;
      @(posedge clk) disable iff (sys_rst)
         cfg.openDrain |-> !padOut && !(padOe && cellValue);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open collector drove high"); // R18

   property p_fb_reg;
      @(posedge clk) disable iff (sys_rst) cfg.fbReg && rstSrc |-> !feedbackOut;
   endproperty
   a_fb_reg: assert property (p_fb_reg) else $error("registered feedback not cleared"); // R12 R10

   property p_locked;
      @(posedge clk) disable iff (sys_rst)
         securityFuse |-> cfgView == '0 && userSig == USER_SIG;
   endproperty
   a_locked: assert property (p_locked) else $error("lock handling wrong"); // R17

   // checked through the storage element, not against the enable logic itself
   property p_blocked_hold;
      @(posedge clk) disable iff (sys_rst)
         (s_gclk_blocked and s_no_async) |=> $stable(qState);
   endproperty
   a_blocked_hold: assert property (p_blocked_hold) else $error("low enable let state move"); // R9

   property p_d_load;
      @(posedge clk) disable iff (sys_rst)
         (s_d_load and s_no_async) |=> qState == $past(dataIn);
   endproperty
   a_d_load: assert property (p_d_load) else $error("edge did not load data"); // R6 R8

   property p_out_driven;
      @(posedge clk) disable iff (sys_rst)
         cfg.ioMode == IO_OUT && !cfg.openDrain |-> padOe && padOut == cellValue;
   endproperty
   a_out_driven: assert property (p_out_driven) else $error("output pin not driven"); // R13

   property p_cascade_in;
      @(posedge clk) disable iff (sys_rst) cfg.cascadeEn && cascadeIn |-> cascadeOut;
   endproperty
   a_cascade_in: assert property (p_cascade_in) else $error("cascade input lost"); // R3

   property p_fb_comb;
      @(posedge clk) disable iff (sys_rst) !cfg.fbReg |-> feedbackOut == xorOut;
   endproperty
   a_fb_comb: assert property (p_fb_comb) else $error("combinatorial feedback wrong"); // R12 R14
endmodule // cm_macrocell

// ===== pkg/cm_regs.svh
// sizes, reset values and fixed counts of the macrocell
`ifndef CM_REGS_SVH
`define CM_REGS_SVH

// ==========================================
// array sizes
`define CM_PT_NUM 5
`define CM_PT_IDX_W 3
`define CM_BLK_IN 40
`define CM_REG_BUS 16
`define CM_GBUS_W 228
`define CM_OE_SUB_W 4
`define CM_OE_SUB_N 16

// ==========================================
// sum limits and widths
`define CM_CASC_MAX 40
`define CM_FOLD_MAX 21
`define CM_SIG_W 16
`define CM_CFG_VIEW_W 16

// ==========================================
// reset values
`define CM_Q_RST 1'b0
`define CM_CLK_PREV_RST 1'b0
`define CM_SIG_DEFAULT 16'h0000

`endif

// ===== pkg/cm_pkg.sv
// types and shared helpers of the macrocell
package cm_pkg;
`include "cm_regs.svh"

   // ==========================================
   // configuration enumerations
   typedef logic [`CM_PT_IDX_W-1:0] cm_pt_idx_t;
   typedef enum logic [1:0] {XOR_PT, XOR_ZERO, XOR_ONE, XOR_FB} cm_xor_t;
   typedef enum logic [1:0] {DSRC_XOR, DSRC_PT, DSRC_PIN} cm_dsrc_t;
   typedef enum logic [2:0] {MODE_D, MODE_T, MODE_JK, MODE_SR, MODE_LATCH} cm_mode_t;
   typedef enum logic {CK_GLOBAL, CK_PT} cm_clk_t;
   typedef enum logic [1:0] {AR_GCLR, AR_PT, AR_OR, AR_OFF} cm_ar_t;
   typedef enum logic {AP_PT, AP_OFF} cm_ap_t;
   typedef enum logic [1:0] {IO_IN, IO_OUT, IO_BIDIR} cm_io_t;
   typedef enum logic [2:0] {OE_EN0, OE_EN0_N, OE_EN1, OE_EN1_N, OE_SUBSET} cm_oe_t;

   // ==========================================
   // configuration word
   typedef struct packed {
      logic [`CM_PT_NUM-1:0] ptToSum;
      logic cascadeEn;
      cm_xor_t xorSel;
      cm_pt_idx_t xorPt;
      cm_dsrc_t dataSrc;
      cm_pt_idx_t dataPt;
      cm_mode_t mode;
      cm_pt_idx_t secPt;
      cm_clk_t clkSel;
      cm_pt_idx_t clkPt;
      logic ceEn;
      cm_pt_idx_t cePt;
      cm_ar_t arSel;
      cm_pt_idx_t arPt;
      cm_ap_t apSel;
      cm_pt_idx_t apPt;
      logic outReg;
      logic fbReg;
      cm_io_t ioMode;
      cm_oe_t oeSel;
      logic [`CM_OE_SUB_W-1:0] oeSubIdx;
      logic openDrain;
      cm_pt_idx_t foldPt;
   } cm_cfg_t;

   // ==========================================
   // storage element controls
   typedef struct packed {
      logic clkRise;
      logic clkLevel;
      logic clkEn;
      logic asyncRst;
      logic asyncSet;
   } cm_ff_ctl_t;

   // pin drive carrier
   typedef struct packed {
      logic out;
      logic oe;
   } cm_pad_t;

   // an index past the last term reads as a quiet zero
   function automatic logic cm_pt_pick(input logic [`CM_PT_NUM-1:0] v, input cm_pt_idx_t i);
      cm_pt_pick = (i < `CM_PT_NUM) ? v[i] : 1'b0;
   endfunction

endpackage

// ===== logic/cm_storage.sv
// configurable storage element: D, T, JK, SR and flow-through latch
`timescale 1ns/1ps
`include "cm_regs.svh"

module cm_storage (
   input wire logic clk, // fabric clock
   input wire logic sys_rst, // synchronous reset, high
   input cm_pkg::cm_mode_t mode, // storage mode
   input wire logic dIn, // data, J or S
   input wire logic kIn, // K or R
   input cm_pkg::cm_ff_ctl_t ctl, // clocking and async controls
   output logic qState, // stored value
   output logic qOut // value with async overrides
);
   import cm_pkg::*;

   logic q_q;
   logic q_d;
   logic update;

   // ==========================================
   // next state
   always_comb begin
      update = ctl.clkEn & ((mode == MODE_LATCH) ? ctl.clkLevel : ctl.clkRise); // R7 R8 R9
      unique case (mode)
         MODE_D: q_d = dIn; // R7
         MODE_T: q_d = q_q ^ dIn; // R7
         MODE_JK: q_d = (dIn & ~q_q) | (~kIn & q_q); // R7
         MODE_SR: q_d = dIn ? 1'b1 : (kIn ? 1'b0 : q_q); // R7
         MODE_LATCH: q_d = dIn; // R7
         default: q_d = q_q;
      endcase
   end

   // ==========================================
   // state; clear beats preset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_q <= `CM_Q_RST;
      end else if (ctl.asyncRst) begin // R19
         q_q <= 1'b0;
      end else if (ctl.asyncSet) begin // R11
         q_q <= 1'b1;
      end else if (update) begin
         q_q <= q_d;
      end
   end

   assign qState = q_q;
   // overrides act without waiting for any clock edge
   assign qOut = ctl.asyncRst ? 1'b0 : (ctl.asyncSet ? 1'b1 : q_q); // R10 R11 R19

   // ==========================================
   // assertions
   sequence s_quiet;
      !ctl.asyncRst && !ctl.asyncSet;
   endsequence

   property p_rst_first;
      @(posedge clk) disable iff (sys_rst) ctl.asyncRst |-> !qOut ##1 !q_q;
   endproperty
   a_rst_first: assert property (p_rst_first) else $error("clear lost to preset"); // R19

   property p_set_acts;
      @(posedge clk) disable iff (sys_rst) (ctl.asyncSet && !ctl.asyncRst) |=> q_q;
   endproperty
   a_set_acts: assert property (p_set_acts) else $error("preset did not set"); // R11

   property p_edge_hold;
      @(posedge clk) disable iff (sys_rst)
         (s_quiet and (mode != MODE_LATCH && !(ctl.clkRise && ctl.clkEn))) |=> $stable(q_q);
   endproperty
   a_edge_hold: assert property (p_edge_hold) else $error("state moved without edge"); // R8 R9

   property p_latch_flow;
      @(posedge clk) disable iff (sys_rst)
         (s_quiet and (mode == MODE_LATCH && ctl.clkLevel && ctl.clkEn)) |=> q_q == $past(dIn);
   endproperty
   a_latch_flow: assert property (p_latch_flow) else $error("latch did not pass data"); // R7

   property p_t_toggle;
      @(posedge clk) disable iff (sys_rst)
         (s_quiet and (mode == MODE_T && ctl.clkRise && ctl.clkEn && dIn)) |=> q_q != $past(q_q);
   endproperty
   a_t_toggle: assert property (p_t_toggle) else $error("toggle mode did not toggle"); // R7
endmodule // cm_storage

// ===== tb/cm_board.sv
// board model at the macrocell pin: drives the line and keeps the pull-up
`timescale 1ns/1ps

module cm_board (
   input wire logic padOut, // cell drive value
   input wire logic padOe, // cell drives, high
   input wire logic drvVal, // board drive value
   input wire logic drvEn, // board drives, high
   output logic padIn, // level seen by the cell
   output logic pinLevel // resolved line level
);
   // ==========================================
   // line resolution
   // a released line never keeps its last value: the pull-up takes it high
   assign pinLevel = padOe ? padOut : (drvEn ? drvVal : 1'h1);
   assign padIn = pinLevel;
endmodule // cm_board

// ===== tb/testbench.sv
// self-checking bench of one macrocell with a board model on its pin
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t: got %h want %h", $time, a, b); end end

module testbench;
   import cm_pkg::*;
   localparam logic [15:0] SIG = 16'hA5C3; // arbitrary signature value
   localparam logic [4:0] OE_EXP = 5'h19;
   logic clk = 1'h0;
   logic sysRst = 1'h1;
   cm_cfg_t cfg;
   logic [227:0] gBus = '0;
   logic [39:0][7:0] mSel;
   logic [15:0] rBus = '0;
   logic [4:0][55:0] ptT;
   logic [4:0][55:0] ptC;
   logic cascade_input = 1'h0, gClk = 1'h0, gClr = 1'h0, fuse = 1'h0, drvVal = 1'h0, drvEn = 1'h0;
   logic [1:0] oePins = 2'h0;
   logic [15:0] oeSub = 16'h0000;
   logic padIn, padOut, padOe, casOut, fbOut, foldOut, pinLevel;
   logic [15:0] userSig, cfgView;
   int error_cnt = 0;
   int n_tests = 0;

   always #5 clk = ~clk;

   cm_macrocell #(.USER_SIG(SIG)) cm_macrocell_i (.clk(clk), .sys_rst(sysRst), .cfg(cfg),
      .globalBus(gBus), .matrixSel(mSel), .regionalBus(rBus), .ptTrueMask(ptT),
      .ptCompMask(ptC), .cascadeIn(cascade_input), .global_clock_line(gClk),
      .global_clear_line(gClr), .oePins(oePins), .oeSubset(oeSub), .padIn(padIn),
      .securityFuse(fuse), .padOut(padOut), .padOe(padOe), .cascadeOut(casOut),
      .feedbackOut(fbOut), .foldbackOut(foldOut), .userSig(userSig), .cfgView(cfgView));

   cm_board cm_board_i (.padOut(padOut), .padOe(padOe), .drvVal(drvVal), .drvEn(drvEn),
      .padIn(padIn), .pinLevel(pinLevel));

   // ==========================================
   // access tasks
   task automatic nx();
      @(negedge clk);
   endtask

   // quiet cell: registered D from term 0, clear line pulsed to empty the store
   task automatic base();
      nx();
      cfg = '0;
      cfg.xorSel = XOR_ZERO;
      cfg.apSel = AP_OFF;
      cfg.ioMode = IO_OUT;
      cfg.outReg = 1'h1;
      cfg.fbReg = 1'h1;
      cfg.secPt = 3'h1;
      cfg.dataSrc = DSRC_PT;
      gBus = '0;
      gClk = 1'h0;
      gClr = 1'h1;
      nx();
      gClr = 1'h0;
   endtask

   // one global clock rise with data d and second input k, then the stored value
   task automatic step(input logic d, input logic k, input logic q);
      gBus[0] = d;
      gBus[1] = k;
      nx();
      gClk = 1'h1;
      nx();
      gClk = 1'h0;
      repeat (2) nx();
      `CHK(fbOut, q)
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================
   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end

   // ==========================================
   // tests
   initial begin
      cfg = '0;
      ptC = '0;
      for (int i = 0; i < 40; i++) mSel[i] = 8'(i);
      for (int k = 0; k < 5; k++) ptT[k] = 56'h1 << k;
      repeat (20) nx();
      sysRst = 1'h0;
      base();
      cfg.outReg = 1'h0;
      cfg.ptToSum = 5'h03;
      gBus[1] = 1'h1;
      nx();
      `CHK(padOut, 1'h1)
      cfg.xorSel = XOR_ONE;
      nx();
      `CHK(padOut, 1'h0)
      cfg.xorSel = XOR_PT;
      cfg.xorPt = 3'h4;
      gBus[4] = 1'h1;
      gBus[1] = 1'h0;
      nx();
      `CHK(padOut, 1'h1)
      `CHK(casOut, 1'h0)
      cascade_input = 1'h1;
      cfg.cascadeEn = 1'h1;
      cfg.foldPt = 3'h4;
      nx();
      `CHK(casOut, 1'h1)
      `CHK(foldOut, 1'h0)
      ptT[4] = 56'h1 << 44;
      nx();
      `CHK(foldOut, 1'h1)
      rBus[4] = 1'h1;
      nx();
      `CHK(foldOut, 1'h0)
      ptT[4] = '0;
      nx();
      `CHK(foldOut, 1'h0)
      ptT[4] = 56'h1 << 4;
      base();
      cfg.outReg = 1'h0;
      cfg.ptToSum = 5'h01;
      mSel[0] = 8'hE3;
      gBus[227] = 1'h1;
      nx();
      `CHK(padOut, 1'h1)
      mSel[0] = 8'h00;
      base();
      step(1, 0, 1);
      step(0, 0, 0);
      cfg.ceEn = 1'h1;
      cfg.cePt = 3'h2;
      step(1, 0, 0);
      gBus[2] = 1'h1;
      step(1, 0, 1);
      base();
      cfg.clkSel = CK_PT;
      cfg.clkPt = 3'h3;
      cfg.ceEn = 1'h1;
      cfg.cePt = 3'h2;
      step(1, 0, 0);
      gBus[3] = 1'h1;
      repeat (2) nx();
      gBus[3] = 1'h0;
      `CHK(fbOut, 1'h1)
      base();
      cfg.mode = MODE_T;
      step(1, 0, 1);
      step(1, 0, 0);
      step(0, 0, 0);
      base();
      cfg.mode = MODE_JK;
      step(1, 0, 1);
      step(1, 1, 0);
      step(0, 0, 0);
      step(1, 1, 1);
      step(0, 1, 0);
      base();
      cfg.mode = MODE_SR;
      step(1, 0, 1);
      step(0, 0, 1);
      step(0, 1, 0);
      step(1, 1, 1);
      base();
      cfg.dataSrc = DSRC_XOR;
      cfg.xorSel = XOR_FB;
      cfg.ptToSum = 5'h01;
      step(1, 0, 1);
      step(1, 0, 0);
      step(0, 0, 0);
      base();
      cfg.mode = MODE_LATCH;
      gClk = 1'h1;
      gBus[0] = 1'h1;
      repeat (2) nx();
      `CHK(fbOut, 1'h1)
      gBus[0] = 1'h0;
      repeat (2) nx();
      `CHK(fbOut, 1'h0)
      gClk = 1'h0;
      nx();
      gBus[0] = 1'h1;
      repeat (2) nx();
      `CHK(fbOut, 1'h0)
      base();
      cfg.dataSrc = DSRC_PIN;
      cfg.ioMode = IO_IN;
      drvEn = 1'h1;
      drvVal = 1'h1;
      step(0, 0, 1);
      `CHK(padOe, 1'h0)
      drvEn = 1'h0;
      base();
      cfg.fbReg = 1'h0;
      cfg.ptToSum = 5'h01;
      gBus[0] = 1'h1;
      repeat (2) nx();
      `CHK(padOut, 1'h0)
      `CHK(fbOut, 1'h1)
      cfg.outReg = 1'h0;
      cfg.fbReg = 1'h1;
      nx();
      `CHK(padOut, 1'h1)
      `CHK(fbOut, 1'h0)
      // every clear source against every mix of clear line and clear term
      for (int s = 0; s < 4; s++) for (int m = 0; m < 4; m++) begin
         logic clr;
         base();
         cfg.arSel = cm_ar_t'(s);
         cfg.arPt = 3'h3;
         cfg.apSel = AP_PT;
         cfg.apPt = 3'h4;
         gBus[4] = 1'h1;
         nx();
         gBus[4] = 1'h0;
         nx();
         gClr = m[0];
         gBus[3] = m[1];
         clr = (s == 0 && m[0]) || (s == 1 && m[1]) || (s == 2 && m != 0);
         nx();
         `CHK(fbOut, !clr)
         gClr = 1'h0;
         gBus[3] = 1'h0;
         repeat (2) nx();
         `CHK(fbOut, !clr)
      end
      cfg.arSel = AR_PT;
      gBus[3] = 1'h1;
      gBus[4] = 1'h1;
      nx();
      `CHK(fbOut, 1'h0)
      gBus[3] = 1'h0;
      nx();
      `CHK(fbOut, 1'h1)
      base();
      cfg.apPt = 3'h4;
      gBus[4] = 1'h1;
      repeat (2) nx();
      `CHK(fbOut, 1'h0)
      `CHK(padOe, 1'h1)
      cfg.outReg = 1'h0;
      cfg.ioMode = IO_BIDIR;
      oePins = 2'h1;
      oeSub = 16'h0020;
      cfg.oeSubIdx = 4'h5;
      for (int o = 0; o < 5; o++) begin
         cfg.oeSel = cm_oe_t'(o);
         nx();
         `CHK(padOe, OE_EXP[o])
      end
      cfg.oeSubIdx = 4'h4;
      nx();
      `CHK(padOe, 1'h0)
      base();
      cfg.outReg = 1'h0;
      cfg.ptToSum = 5'h01;
      cfg.openDrain = 1'h1;
      nx();
      `CHK(padOe, 1'h1)
      `CHK(pinLevel, 1'h0)
      gBus[0] = 1'h1;
      nx();
      `CHK(padOe, 1'h0)
      `CHK(pinLevel, 1'h1)
      `CHK(cfgView, cfg[15:0])
      fuse = 1'h1;
      nx();
      `CHK(cfgView, 16'h0000)
      `CHK(userSig, SIG)
      wrap_up();
   end
endmodule // testbench
